//--- verilog/frs_pkg.sv
// package for the fundamental reset sequencer: timing, modes, carriers
package frs_pkg;
	// clock rate
	localparam int CLK_HZ = 40000000;
	// longest times, in their own units
	localparam int LINK_TRAIN_MS = 20;
	localparam int CFG_RETRY_MS = 100;
	localparam int EE_LOAD_MS = 200;
	localparam int NORMAL_OP_MS = 1000;
	// cycle counts, rounded down for deadlines
	localparam int LINK_TRAIN_CYC = LINK_TRAIN_MS * (CLK_HZ / 1000);
	localparam int CFG_RETRY_CYC = CFG_RETRY_MS * (CLK_HZ / 1000);
	localparam int EE_LOAD_CYC = EE_LOAD_MS * (CLK_HZ / 1000);
	localparam int NORMAL_OP_CYC = NORMAL_OP_MS * (CLK_HZ / 1000);
	// mode select encodings
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_EEPROM = 3'h1;
	// reset values and port count
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam int NUM_PORTS = 3;

	// sequencer states
	typedef enum logic [3:0] {
		FRS_WAIT_RST,
		FRS_SAMPLE,
		FRS_PLL,
		FRS_TRAIN,
		FRS_QUASI,
		FRS_EE_LOAD,
		FRS_HALT,
		FRS_NORMAL,
		FRS_WARM_WAIT
	} frs_state_t;

	// one register write from the eeprom loader
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [31:0] data;
	} frs_ee_wr_t;

	// eeprom loader result
	typedef struct packed {
		logic done;
		logic error;
		logic [7:0] err_code;
	} frs_ee_res_t;
endpackage : frs_pkg

//--- verilog/frs_sequencer.sv
// fundamental reset sequencer for normal mode with optional eeprom load
//
// Behaviour
// RULE1 - start only after fundamental reset clears
// RULE2 - latch boot pins on negation, else reuse
// RULE3 - decode latched mode; 0x1 means eeprom init
// RULE4 - 0x0 normal, 0x1 eeprom, higher reserved
// RULE5 - init pll/serdes, then training, in parallel
// RULE6 - halt pin asserted sets status halt flag
// RULE7 - release stacks but hold quasi-reset until normal
// RULE8 - links training within 20 ms of clear
// RULE9 - retry configuration requests within 100 ms
// RULE10 - eeprom mode loads registers from eeprom
// RULE11 - loaded retrain bit retrains that port's link
// RULE12 - load error aborts, sets halt, records error
// RULE13 - done flag set on completion or error
// RULE14 - halt bit holds logic until software clears
// RULE15 - during halt, service register and eeprom access
// RULE16 - after halt or none, enter normal operation
// RULE17 - side effects fire at the write itself
// RULE18 - image should configure before side-effect writes
// RULE19 - complete warm reset write before starting reset
// RULE20 - on reset all gpio revert to input
// RULE21 - reset starts by pin or software bit
`timescale 1ns/100ps
module frs_sequencer #(
	parameter int LINK_TRAIN_CYC = frs_pkg::LINK_TRAIN_CYC,
	parameter int CFG_RETRY_CYC = frs_pkg::CFG_RETRY_CYC,
	parameter int PLL_CYC = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// board pins, asynchronous
	input wire logic fundamental_reset_n,
	input wire logic [2:0] operating_mode_select,
	input wire logic hold_after_reset,
	// pll and serdes
	output logic pll_init,
	input wire logic pll_locked,
	// link training
	output logic link_train_start,
	input wire logic [frs_pkg::NUM_PORTS-1:0] link_training_active,
	output logic [frs_pkg::NUM_PORTS-1:0] port_retrain,
	// protocol stacks
	output logic stack_reset,
	output logic stack_quasi_reset,
	output logic core_reset,
	output logic normal_op,
	// eeprom loader
	output logic ee_load_start,
	input wire frs_pkg::frs_ee_wr_t ee_wr,
	input wire frs_pkg::frs_ee_res_t ee_res,
	// software controls from the register block
	input wire logic warm_reset_trigger_bit,
	input wire logic warm_reset_cpl_sent,
	input wire logic halt_clear,
	input wire logic [15:0] phy_link_state_zero_addr,
	input wire logic [4:0] full_link_retrain_pos,
	// status out
	output logic status_halt_flag,
	output logic control_halt_bit,
	output logic serial_mgmt_done,
	output logic [7:0] serial_mgmt_err,
	output logic ext_access_ok,
	output logic [2:0] mode_latched,
	output logic mode_eeprom,
	output logic mode_reserved,
	output logic retry_deadline_miss,
	output logic train_deadline_miss,
	// gpio direction
	output logic [frs_pkg::NUM_PORTS-1:0] gpio_oe
);
	// synchronisers for board pins; first stages may be metastable
	logic rstn_s1; // reset pin, first stage
	logic rstn_s2; // reset pin, safe to read
	logic halt_s1; // halt pin, first stage
	logic halt_s2; // halt pin, safe to read
	logic [2:0] mode_s1; // boot pins, first stage
	logic [2:0] mode_s2; // boot pins, safe to read
	// sequencer bookkeeping
	logic rstn_prev; // for the negation edge
	frs_pkg::frs_state_t state_reg; // current step
	frs_pkg::frs_state_t state_next; // step after this edge
	logic [31:0] since_clear; // cycles since reset cleared
	logic [31:0] pll_cnt; // cycles spent in pll init
	logic warm_pending; // sw reset armed, waiting for completion
	logic rise; // one-cycle pulse on reset negation

	// decode eeprom mode from a latched value
	function automatic logic is_ee_mode(input logic [2:0] m);
		return m == frs_pkg::MODE_EEPROM; // see RULE3 see RULE4
	endfunction : is_ee_mode

	// two flip-flop synchronisers; first stage read only by second
	// boot pins are quiet around negation, so a per-bit
	// synchroniser is enough for the mode word
	always_ff @(posedge clk) begin
		if (rst) begin
			rstn_s1 <= 1'b0;
			rstn_s2 <= 1'b0;
			halt_s1 <= 1'b0;
			halt_s2 <= 1'b0;
			mode_s1 <= frs_pkg::MODE_RESET;
			mode_s2 <= frs_pkg::MODE_RESET;
		end else begin
			rstn_s1 <= fundamental_reset_n;
			rstn_s2 <= rstn_s1;
			halt_s1 <= hold_after_reset;
			halt_s2 <= halt_s1;
			mode_s1 <= operating_mode_select;
			mode_s2 <= mode_s1;
		end
	end

	// edge tracking on the synchronised reset pin
	// zero after reset, so a pin already high then counts as negation
	always_ff @(posedge clk) begin
		if (rst)
			rstn_prev <= 1'b0;
		else
			rstn_prev <= rstn_s2;
	end
	// rise marks the first cycle the synchronised pin is high
	assign rise = rstn_s2 && !rstn_prev;

	// boot pin latch; software resets keep the old values
	// a warm reset from software never makes rise, so nothing reloads
	always_ff @(posedge clk) begin
		if (rst)
			mode_latched <= frs_pkg::MODE_RESET;
		else if (rise)
			mode_latched <= mode_s2; // see RULE2
	end
	assign mode_eeprom = is_ee_mode(mode_latched);
	assign mode_reserved = mode_latched > frs_pkg::MODE_EEPROM; // see RULE4

	// software warm reset: wait for the write completion first
	// a pin reset cancels any software reset still pending
	always_ff @(posedge clk) begin
		if (rst || !rstn_s2)
			warm_pending <= 1'b0;
		else if (warm_reset_trigger_bit)
			warm_pending <= 1'b1; // see RULE21
		else if (state_reg == frs_pkg::FRS_WARM_WAIT && warm_reset_cpl_sent)
			warm_pending <= 1'b0;
	end

	// next state
	// reserved modes take the plain normal path, with no load
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			frs_pkg::FRS_WAIT_RST:
				if (rstn_s2)
					state_next = frs_pkg::FRS_SAMPLE; // see RULE1
			frs_pkg::FRS_SAMPLE:
				state_next = frs_pkg::FRS_PLL;
			frs_pkg::FRS_PLL:
				if (pll_locked && pll_cnt >= 32'(PLL_CYC))
					state_next = frs_pkg::FRS_TRAIN; // see RULE5
			frs_pkg::FRS_TRAIN:
				state_next = frs_pkg::FRS_QUASI;
			frs_pkg::FRS_QUASI:
				if (is_ee_mode(mode_latched))
					state_next = frs_pkg::FRS_EE_LOAD; // see RULE10
				else if (control_halt_bit)
					state_next = frs_pkg::FRS_HALT;
				else
					state_next = frs_pkg::FRS_NORMAL;
			// an error always halts; success halts only when asked
			frs_pkg::FRS_EE_LOAD:
				if (ee_res.done || ee_res.error)
					state_next = (control_halt_bit || ee_res.error) ?
						frs_pkg::FRS_HALT : frs_pkg::FRS_NORMAL;
			frs_pkg::FRS_HALT:
				if (!control_halt_bit)
					state_next = frs_pkg::FRS_NORMAL; // see RULE16
			frs_pkg::FRS_NORMAL:
				if (warm_pending)
					state_next = frs_pkg::FRS_WARM_WAIT;
			// the completion leaves before the warm reset begins
			frs_pkg::FRS_WARM_WAIT:
				if (warm_reset_cpl_sent)
					state_next = frs_pkg::FRS_SAMPLE; // see RULE19
			default:
				state_next = frs_pkg::FRS_WAIT_RST;
		endcase
	end

	// state register; the pin reset overrides everything
	// holding wait while the pin is low stops any early start
	always_ff @(posedge clk) begin
		if (rst || !rstn_s2)
			state_reg <= frs_pkg::FRS_WAIT_RST; // see RULE21
		else
			state_reg <= state_next;
	end

	// pll settle counter
	// lock alone is not trusted; the count sets a least settle time
	always_ff @(posedge clk) begin
		if (rst || state_reg != frs_pkg::FRS_PLL)
			pll_cnt <= '0;
		else if (pll_cnt < 32'(PLL_CYC))
			pll_cnt <= pll_cnt + 32'd1;
	end

	// time since the reset condition cleared, saturating
	// starts at the first pll cycle, a few cycles after the pin rises
	always_ff @(posedge clk) begin
		if (rst || state_reg == frs_pkg::FRS_WAIT_RST ||
			state_reg == frs_pkg::FRS_SAMPLE)
			since_clear <= '0;
		else if (since_clear != '1)
			since_clear <= since_clear + 32'd1;
	end

	// deadline monitors; a miss is flagged for software
	// each is checked once at its exact count; saturation stops a wrap
	always_ff @(posedge clk) begin
		if (rst || state_reg == frs_pkg::FRS_SAMPLE) begin
			train_deadline_miss <= 1'b0;
			retry_deadline_miss <= 1'b0;
		end else begin
			// every link should be training by now
			if (since_clear == 32'(LINK_TRAIN_CYC) &&
				link_training_active != '1)
				train_deadline_miss <= 1'b1; // see RULE8
			// stacks should answer with retry, or already run
			if (since_clear == 32'(CFG_RETRY_CYC) && !stack_quasi_reset &&
				!normal_op)
				retry_deadline_miss <= 1'b1; // see RULE9
		end
	end

	// status halt flag from the pin, sampled during the sequence
	// read only as training starts, so a late pin is ignored
	always_ff @(posedge clk) begin
		if (rst || state_reg == frs_pkg::FRS_SAMPLE)
			status_halt_flag <= 1'b0;
		else if (state_reg == frs_pkg::FRS_TRAIN && halt_s2)
			status_halt_flag <= 1'b1; // see RULE6
	end

	// control halt bit: pin or load error sets, software clears
	// a set wins over a clear that lands in the same cycle
	always_ff @(posedge clk) begin
		if (rst)
			control_halt_bit <= 1'b0;
		else if (state_reg == frs_pkg::FRS_TRAIN && halt_s2)
			control_halt_bit <= 1'b1; // see RULE6
		else if (state_reg == frs_pkg::FRS_EE_LOAD && ee_res.error)
			control_halt_bit <= 1'b1; // see RULE12
		// software clear, only when nothing sets it
		else if (halt_clear)
			control_halt_bit <= 1'b0; // see RULE14
	end

	// eeprom done and error record; a new sequence clears them
	// the error code stands until the next sequence for software
	always_ff @(posedge clk) begin
		if (rst || state_reg == frs_pkg::FRS_SAMPLE) begin
			serial_mgmt_done <= 1'b0;
			serial_mgmt_err <= frs_pkg::ERR_RESET;
		end else if (state_reg == frs_pkg::FRS_EE_LOAD) begin
			if (ee_res.done || ee_res.error)
				serial_mgmt_done <= 1'b1; // see RULE13
			if (ee_res.error)
				serial_mgmt_err <= ee_res.err_code; // see RULE12
		end
	end

	// load start pulse on entering the load state
	// registered, so the loader sees it in the first load cycle
	always_ff @(posedge clk) begin
		if (rst)
			ee_load_start <= 1'b0;
		else
			ee_load_start <= state_reg == frs_pkg::FRS_QUASI &&
				state_next == frs_pkg::FRS_EE_LOAD; // see RULE10
	end

	// retrain pulses fire on the write itself, not at load end
	// a write that comes with an error is dropped, not half done
	always_ff @(posedge clk) begin
		if (rst)
			port_retrain <= '0;
		else begin
			for (int p = 0; p < frs_pkg::NUM_PORTS; p++)
				port_retrain[p] <= state_reg == frs_pkg::FRS_EE_LOAD &&
					ee_wr.valid && !ee_res.error &&
					ee_wr.addr == phy_link_state_zero_addr + 16'(p) &&
					ee_wr.data[full_link_retrain_pos]; // see RULE11 see RULE17
		end
	end

	// pll, training and stack controls
	// driven from state_next so each output moves with its state; link_train_start is from state_reg, a cycle late
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_init <= 1'b0;
			link_train_start <= 1'b0;
			stack_reset <= 1'b1;
			stack_quasi_reset <= 1'b0;
			core_reset <= 1'b1;
			normal_op <= 1'b0;
		end else begin
			pll_init <= state_next == frs_pkg::FRS_PLL; // see RULE5
			link_train_start <= state_reg == frs_pkg::FRS_TRAIN;
			// stacks leave reset once training is under way
			stack_reset <= !(state_next == frs_pkg::FRS_QUASI ||
				state_next == frs_pkg::FRS_EE_LOAD ||
				state_next == frs_pkg::FRS_HALT ||
				state_next == frs_pkg::FRS_NORMAL ||
				state_next == frs_pkg::FRS_WARM_WAIT); // see RULE7
			stack_quasi_reset <= state_next == frs_pkg::FRS_QUASI ||
				state_next == frs_pkg::FRS_EE_LOAD ||
				state_next == frs_pkg::FRS_HALT; // see RULE9 see RULE7
			// all other logic waits in reset until normal operation
			core_reset <= state_next != frs_pkg::FRS_NORMAL &&
				state_next != frs_pkg::FRS_WARM_WAIT; // see RULE14
			normal_op <= state_next == frs_pkg::FRS_NORMAL ||
				state_next == frs_pkg::FRS_WARM_WAIT; // see RULE16
		end
	end

	// external agent access allowed while halted or running
	// the register block gates outside accesses on this level
	assign ext_access_ok = state_reg == frs_pkg::FRS_HALT ||
		state_reg == frs_pkg::FRS_NORMAL; // see RULE15

	// all gpio to input on any fundamental reset
	// no direction control lives here, so every pin stays an input
	always_ff @(posedge clk) begin
		if (rst)
			gpio_oe <= '0;
		else if (state_reg == frs_pkg::FRS_WAIT_RST ||
			state_reg == frs_pkg::FRS_SAMPLE)
			gpio_oe <= '0; // see RULE20
		else if (state_reg == frs_pkg::FRS_NORMAL)
			gpio_oe <= gpio_oe;
	end
endmodule : frs_sequencer

//--- verif/frs_seq_monitor.sv
// assertion checker for the fundamental reset sequencer
`timescale 1ns/100ps
module frs_seq_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins, loader, software
	input wire logic fundamental_reset_n,
	input wire logic ee_load_start,
	input wire frs_pkg::frs_ee_wr_t ee_wr,
	input wire frs_pkg::frs_ee_res_t ee_res,
	input wire logic warm_reset_trigger_bit,
	input wire logic warm_reset_cpl_sent,
	input wire logic [15:0] phy_link_state_zero_addr,
	input wire logic [4:0] full_link_retrain_pos,
	// sequencer outputs
	input wire logic pll_init,
	input wire logic link_train_start,
	input wire logic [frs_pkg::NUM_PORTS-1:0] port_retrain,
	input wire logic stack_reset,
	input wire logic stack_quasi_reset,
	input wire logic normal_op,
	input wire logic control_halt_bit,
	input wire logic serial_mgmt_done,
	input wire logic [7:0] serial_mgmt_err,
	input wire logic [2:0] mode_latched,
	input wire logic mode_eeprom,
	input wire logic mode_reserved,
	input wire logic [frs_pkg::NUM_PORTS-1:0] gpio_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic load_reg; // an eeprom load is under way
	logic warm_reg; // warm reset waits for its completion
	// track load and warm windows; pin reset ends a load
	always_ff @(posedge clk) begin
		if (rst || !fundamental_reset_n) load_reg <= 1'b0;
		else if (ee_load_start) load_reg <= 1'b1;
		else if ($rose(serial_mgmt_done)) load_reg <= 1'b0;
		if (rst || warm_reset_cpl_sent) warm_reg <= 1'b0;
		else if (warm_reset_trigger_bit) warm_reg <= 1'b1;
	end
	sequence s_err;
		load_reg && ee_res.error;
	endsequence
	sequence s_stop;
		serial_mgmt_done && control_halt_bit;
	endsequence
	property p_err;
		s_err |=> s_stop ##0 (serial_mgmt_err == $past(ee_res.err_code));
	endproperty
	a_err: assert property (p_err)
		else $error("load error not flagged");
	property p_wait;
		!fundamental_reset_n [*6] |-> !pll_init && !normal_op;
	endproperty
	a_wait: assert property (p_wait)
		else $error("ran while pin low");
	property p_mode;
		mode_eeprom == (mode_latched == frs_pkg::MODE_EEPROM)
		&& mode_reserved == (mode_latched > 3'h1);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode decode wrong");
	property p_train;
		$fell(pll_init) |-> ##[0:3] link_train_start;
	endproperty
	a_train: assert property (p_train) else $error("no training");
	property p_quasi;
		stack_quasi_reset |-> !stack_reset;
	endproperty
	a_quasi: assert property (p_quasi) else $error("quasi in reset");
	property p_halt;
		control_halt_bit |-> !normal_op;
	endproperty
	a_halt: assert property (p_halt)
		else $error("ran while halted");
	property p_norm;
		normal_op [*2] |-> !stack_quasi_reset;
	endproperty
	a_norm: assert property (p_norm) else $error("quasi in normal");
	property p_retrain;
		load_reg && ee_wr.valid && !ee_res.error
		&& ee_wr.addr == phy_link_state_zero_addr + 16'h1
		&& ee_wr.data[full_link_retrain_pos] |-> ##[1:2] port_retrain[1];
	endproperty
	a_retrain: assert property (p_retrain)
		else $error("no retrain");
	property p_warm;
		warm_reg |-> !pll_init;
	endproperty
	a_warm: assert property (p_warm) else $error("warm too early");
	property p_gpio;
		gpio_oe == '0;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio driven");
endmodule : frs_seq_monitor
bind frs_sequencer frs_seq_monitor u_mon (.clk, .rst, .fundamental_reset_n,
	.ee_load_start, .ee_wr, .ee_res, .warm_reset_trigger_bit,
	.warm_reset_cpl_sent, .phy_link_state_zero_addr, .full_link_retrain_pos,
	.pll_init, .link_train_start, .port_retrain, .stack_reset,
	.stack_quasi_reset, .normal_op, .control_halt_bit, .serial_mgmt_done,
	.serial_mgmt_err, .mode_latched, .mode_eeprom, .mode_reserved, .gpio_oe);

//--- verif/frs_far_model.sv
// far-side model: pll, link partners and serial eeprom loader
`timescale 1ns/100ps
module frs_far_model (
	// clock
	input wire logic clk,
	// requests from the sequencer
	input wire logic pll_init,
	input wire logic ee_load_start,
	// scenario knobs
	input wire logic ee_fail,
	input wire logic slow,
	// answers
	output logic pll_locked = 0,
	output logic [frs_pkg::NUM_PORTS-1:0] link_training_active = 0,
	output frs_pkg::frs_ee_wr_t ee_wr = '0,
	output frs_pkg::frs_ee_res_t ee_res = '0
);
	logic pll_q = 0; // init seen last cycle
	int t = 0; // cycles since pll init
	int n = 0; // loader step, 0 when idle
	// lock drops on re-init; links come up late when slow
	always @(posedge clk) begin
		pll_q <= pll_init;
		if (pll_init) pll_locked <= pll_q;
		t <= pll_init ? 0 : t + 1;
		link_training_active <= {3{t >= (slow ? 180 : 30)}};
		n <= ee_load_start ? 1 : (n != 0 && n < 9) ? n + 1 : 0;
		// config write first, retrain write later
		ee_wr.valid <= n == 4 || n == 6;
		ee_wr.addr <= n == 6 ? 16'h0041 : n == 4 ? 16'h0010 : ~ee_wr.addr;
		ee_wr.data <= n == 6 ? 32'h00002000 : ~ee_wr.data;
		ee_res.done <= n == 8 && !ee_fail;
		ee_res.error <= n == 8 && ee_fail;
		ee_res.err_code <= n == 8 ? 8'h5a : ~ee_res.err_code;
	end
endmodule : frs_far_model

//--- verif/testbench.sv
// self-checking bench for the fundamental reset sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin for (k = 0; k < 4000 && (c) !== 1'b1; k++) begin \
	@(posedge clk); #1; end if ((c) !== 1'b1) begin error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, c, 1'b1); \
	end_of_test(); end end
module testbench;
	// stimulus
	logic clk = 0, rst = 1, fundamental_reset_n = 0, hold_after_reset = 0;
	logic [2:0] operating_mode_select = 0;
	logic warm_reset_trigger_bit = 0, warm_reset_cpl_sent = 0;
	logic halt_clear = 0, ee_fail = 0, slow = 0;
	// observed
	logic pll_init, pll_locked, link_train_start, stack_reset, core_reset;
	logic stack_quasi_reset, normal_op, ee_load_start, status_halt_flag;
	logic control_halt_bit, serial_mgmt_done, ext_access_ok, mode_eeprom;
	logic mode_reserved, retry_deadline_miss, train_deadline_miss;
	logic [2:0] link_training_active, port_retrain, gpio_oe, mode_latched;
	logic [7:0] serial_mgmt_err;
	frs_pkg::frs_ee_wr_t ee_wr;
	frs_pkg::frs_ee_res_t ee_res;
	int error_cnt = 0, n_compared = 0, k;
	logic saw_rt = 0; // port 1 retrain pulse seen
	// rows: mode, expect eeprom, expect reserved
	localparam logic [4:0] ROWS [8] = '{5'h00, 5'h06, 5'h09, 5'h0d,
		5'h11, 5'h15, 5'h19, 5'h1d};
	// short counts keep deadlines reachable in simulation
	frs_sequencer #(.LINK_TRAIN_CYC(100), .CFG_RETRY_CYC(400)) uut (.clk,
		.rst, .fundamental_reset_n, .operating_mode_select, .hold_after_reset,
		.pll_init, .pll_locked, .link_train_start, .link_training_active,
		.port_retrain, .stack_reset, .stack_quasi_reset, .core_reset,
		.normal_op, .ee_load_start, .ee_wr, .ee_res, .warm_reset_trigger_bit,
		.warm_reset_cpl_sent, .halt_clear, .phy_link_state_zero_addr(16'h0040),
		.full_link_retrain_pos(5'h0d), .status_halt_flag, .control_halt_bit,
		.serial_mgmt_done, .serial_mgmt_err, .ext_access_ok, .mode_latched,
		.mode_eeprom, .mode_reserved, .retry_deadline_miss,
		.train_deadline_miss, .gpio_oe);
	frs_far_model far (.clk, .pll_init, .ee_load_start, .ee_fail, .slow,
		.pll_locked, .link_training_active, .ee_wr, .ee_res);
	// clock
	initial forever #12.5 clk = ~clk;
	// remember retrain pulses
	always @(posedge clk) if (port_retrain[1]) saw_rt <= 1'b1;
	// report counts and verdict, then stop
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// pin reset with given boot pins
	task automatic boot(input logic [2:0] m, input logic h);
		@(posedge clk);
		fundamental_reset_n <= 1'b0;
		operating_mode_select <= m;
		hold_after_reset <= h;
		repeat (8) @(posedge clk);
		fundamental_reset_n <= 1'b1;
		@(posedge clk);
		#1;
	endtask : boot
	// one-cycle software strobe on halt_clear
	task automatic clr_halt();
		@(posedge clk);
		halt_clear <= 1'b1;
		@(posedge clk);
		halt_clear <= 1'b0;
	endtask : clr_halt
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(stack_reset, 1'b1)
		`CHK(core_reset, 1'b1)
		repeat (10) @(posedge clk);
		#1;
		`CHK(pll_init, 1'b0)
		`CHK(gpio_oe, 3'h0)
		$display("test reset done");
		foreach (ROWS[i]) begin
			boot(ROWS[i][4:2], 1'b0);
			`WAITC(normal_op)
			repeat (420) @(posedge clk);
			#1;
			`CHK(mode_latched, ROWS[i][4:2])
			`CHK(mode_eeprom, ROWS[i][1])
			`CHK(mode_reserved, ROWS[i][0])
			`CHK(serial_mgmt_done, ROWS[i][1])
			`CHK(stack_quasi_reset, 1'b0)
			`CHK(train_deadline_miss, 1'b0)
			`CHK(retry_deadline_miss, 1'b0)
		end
		`CHK(saw_rt, 1'b1)
		$display("test modes done");
		boot(3'h0, 1'b1);
		`WAITC(control_halt_bit)
		`CHK(status_halt_flag, 1'b1)
		repeat (20) @(posedge clk);
		#1;
		`CHK(normal_op, 1'b0)
		`CHK(ext_access_ok, 1'b1)
		clr_halt();
		`WAITC(normal_op)
		$display("test halt done");
		ee_fail <= 1'b1;
		boot(3'h1, 1'b0);
		`WAITC(serial_mgmt_done)
		`CHK(control_halt_bit, 1'b1)
		`CHK(serial_mgmt_err, 8'h5a)
		ee_fail <= 1'b0;
		clr_halt();
		`WAITC(normal_op)
		$display("test load error done");
		@(posedge clk);
		operating_mode_select <= 3'h0;
		warm_reset_trigger_bit <= 1'b1;
		@(posedge clk);
		warm_reset_trigger_bit <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		`CHK(pll_init, 1'b0)
		@(posedge clk);
		warm_reset_cpl_sent <= 1'b1;
		@(posedge clk);
		warm_reset_cpl_sent <= 1'b0;
		`WAITC(pll_init)
		`WAITC(serial_mgmt_done)
		`CHK(mode_latched, 3'h1)
		`CHK(control_halt_bit, 1'b0)
		$display("test warm reset done");
		slow <= 1'b1;
		boot(3'h0, 1'b0);
		`WAITC(train_deadline_miss)
		`CHK(link_training_active, 3'h0)
		$display("test slow links done");
		end_of_test();
	end
endmodule : testbench
